// file: irc_clk_partner.sv
// Clock sources facing the codec: the crystal oscillator cell and the external sixteen-times clock.
`timescale 1ns/1ns
`default_nettype none

module irc_clk_partner #(
	parameter int XTAL_HALF = 4,
	parameter int BAUD_HALF = 6
) (
	input  wire logic hclk,
	input  wire logic osc_run_out,
	output var  logic crystal_clock_in,
	output var  logic baud_x16_clock
);
	int xcnt = 0;
	int bcnt = 0;
	initial crystal_clock_in = 1'b0;
	initial baud_x16_clock = 1'b0;
	// ==========================================================
	// Oscillator cell: it stands still while the codec holds it asleep.
	always @(posedge hclk)
	begin
		if (osc_run_out)
		begin
			xcnt <= (xcnt == XTAL_HALF - 1) ? 0 : xcnt + 1;
			if (xcnt == XTAL_HALF - 1)
				crystal_clock_in <= ~crystal_clock_in;
		end
	end
	// ==========================================================
	// The external clock runs free, so it is there whenever the crystal is deselected.
	always @(posedge hclk)
	begin
		bcnt <= (bcnt == BAUD_HALF - 1) ? 0 : bcnt + 1;
		if (bcnt == BAUD_HALF - 1)
			baud_x16_clock <= ~baud_x16_clock;
	end
endmodule : irc_clk_partner
`default_nettype wire

// file: irc_codec.sv
// Infrared pulse encoder and decoder with clock source selection and an AHB-Lite register slave.
`timescale 1ns/1ns
`default_nettype none

module irc_codec (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic [31:0] hrdata,
	output var  logic        hreadyout,
	output var  logic        hresp,
	input  wire logic        uart_tx_in,
	output var  logic        uart_rx_out,
	input  wire logic        optical_rx_in,
	output var  logic        optical_tx_out,
	input  wire logic        fixed_pulse_select,
	input  wire logic        osc_sleep_in,
	input  wire logic        clock_select_ext,
	input  wire logic        baud_x16_clock,
	input  wire logic        crystal_clock_in,
	input  wire logic        codec_reset_n,
	output var  logic        osc_run_out
);
	import irc_pkg::*;

	// ==========================================================
	// Pin synchronisers and edge detection
	logic [PIN_W-1:0] pin_meta_q;
	logic [PIN_W-1:0] pin_sync_q;
	logic [PIN_W-1:0] pin_prev_q;
	logic             tx_s;
	logic             fixed_s;
	logic             clk_ext_s;
	logic             codec_rstn_s;
	logic             tx_fall;
	logic             rx_rise;
	logic             baud_rise;
	logic             xtal_rise;
	logic             x16_tick;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_meta_q <= PIN_RESET;
			pin_sync_q <= PIN_RESET;
			pin_prev_q <= PIN_RESET;
		end
		else
		begin
			pin_meta_q <= {codec_reset_n, crystal_clock_in, baud_x16_clock, clock_select_ext,
				osc_sleep_in, fixed_pulse_select, optical_rx_in, uart_tx_in};
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	assign tx_s         = pin_sync_q[PIN_TX];
	assign fixed_s      = pin_sync_q[PIN_FIXED];
	assign clk_ext_s    = pin_sync_q[PIN_CLK_EXT];
	assign codec_rstn_s = pin_sync_q[PIN_CODEC_RSTN];
	assign tx_fall      = pin_prev_q[PIN_TX] & ~tx_s;
	assign rx_rise      = pin_sync_q[PIN_RX] & ~pin_prev_q[PIN_RX];
	assign baud_rise    = pin_sync_q[PIN_BAUD] & ~pin_prev_q[PIN_BAUD];
	assign xtal_rise    = pin_sync_q[PIN_XTAL] & ~pin_prev_q[PIN_XTAL] & osc_run_out;
	assign x16_tick     = clk_ext_s ? baud_rise : xtal_rise;

	// ==========================================================
	// Oscillator control
	logic osc_run_d;

	always_comb
	begin
		osc_run_d = ~(pin_sync_q[PIN_SLEEP] | clk_ext_s);
	end

	// ==========================================================
	// Register slave
	logic [1:0]  ctrl_q;
	logic [1:0]  ctrl_d;
	logic        wr_pend_q;
	logic        wr_pend_d;
	logic [7:0]  wr_addr_q;
	logic [7:0]  wr_addr_d;
	logic [31:0] rdata_d;
	logic        access;
	logic [4:0]  status;

	assign access = hsel & hready & htrans[1];

	always_comb
	begin
		wr_pend_d = access & hwrite;
		wr_addr_d = access ? haddr[7:0] : wr_addr_q;
		ctrl_d    = ctrl_q;
		if (wr_pend_q && (wr_addr_q == CTRL_OFFSET))
		begin
			ctrl_d = hwdata[1:0];
		end
		rdata_d = 32'h0000_0000;
		if (access && !hwrite && (haddr[7:0] == CTRL_OFFSET) && (haddr[31:8] == 24'h00_0000))
		begin
			rdata_d = {30'h0, ctrl_q};
		end
		else if (access && !hwrite && (haddr[7:0] == STATUS_OFFSET) && (haddr[31:8] == 24'h00_0000))
		begin
			rdata_d = {27'h0, status};
		end
	end

	// ==========================================================
	// Encoder
	irc_enc_state_t   enc_state_q;
	irc_enc_state_t   enc_state_d;
	logic             enc_fixed_q;
	logic             enc_fixed_d;
	logic             enc_start;
	logic             enc_busy;
	logic             enc_done;
	logic [CNT_W-1:0] enc_cnt;
	logic             enc_restart;
	logic             tx_out_d;

	always_comb
	begin
		enc_restart = enc_done & ~enc_fixed_q & ~tx_s & ctrl_q[CTRL_TX_EN_BIT];
		enc_start   = codec_rstn_s & ((enc_state_q == ENC_IDLE) & tx_fall & ctrl_q[CTRL_TX_EN_BIT]
			| enc_restart);
		enc_fixed_d = enc_start && (enc_state_q == ENC_IDLE) ? fixed_s : enc_fixed_q;
		enc_state_d = enc_state_q;
		unique case (enc_state_q)
			ENC_IDLE:
			begin
				if (enc_start)
					enc_state_d = ENC_PULSE;
			end
			ENC_PULSE:
			begin
				if (enc_done && !enc_restart)
					enc_state_d = ENC_IDLE;
			end
		endcase
		if (!codec_rstn_s)
			enc_state_d = ENC_IDLE;
		tx_out_d = enc_busy & (enc_fixed_q | (enc_cnt < X16_PULSE_TICKS));
	end

	irc_tick_timer #(.W(CNT_W)) u_enc_timer (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clear   (~codec_rstn_s),
		.start   (enc_start),
		.tick    (enc_fixed_q ? xtal_rise : x16_tick),
		.limit   (enc_fixed_q ? FIXED_PULSE_TICKS : X16_PER_BIT),
		.busy_q  (enc_busy),
		.count_q (enc_cnt),
		.done    (enc_done)
	);

	// ==========================================================
	// Decoder
	irc_dec_state_t   dec_state_q;
	irc_dec_state_t   dec_state_d;
	logic             dec_start;
	logic             dec_busy;
	logic             dec_done;
	logic [CNT_W-1:0] dec_cnt;

	always_comb
	begin
		dec_start   = codec_rstn_s & (dec_state_q == DEC_IDLE) & rx_rise & ctrl_q[CTRL_RX_EN_BIT];
		dec_state_d = dec_state_q;
		unique case (dec_state_q)
			DEC_IDLE:
			begin
				if (dec_start)
					dec_state_d = DEC_LOW;
			end
			DEC_LOW:
			begin
				if (dec_done)
					dec_state_d = DEC_IDLE;
			end
		endcase
		if (!codec_rstn_s)
			dec_state_d = DEC_IDLE;
	end

	irc_tick_timer #(.W(CNT_W)) u_dec_timer (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clear   (~codec_rstn_s),
		.start   (dec_start),
		.tick    (x16_tick),
		.limit   (X16_PER_BIT),
		.busy_q  (dec_busy),
		.count_q (dec_cnt),
		.done    (dec_done)
	);

	assign status = {clk_ext_s, enc_fixed_q, osc_run_out, dec_busy, enc_busy};

	// ==========================================================
	// State and output registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_q         <= CTRL_RESET;
			wr_pend_q      <= 1'b0;
			wr_addr_q      <= 8'h00;
			hrdata         <= 32'h0000_0000;
			hreadyout      <= 1'b1;
			hresp          <= 1'b0;
			enc_state_q    <= ENC_IDLE;
			enc_fixed_q    <= 1'b0;
			dec_state_q    <= DEC_IDLE;
			optical_tx_out <= 1'b0;
			uart_rx_out    <= 1'b1;
			osc_run_out    <= 1'b1;
		end
		else
		begin
			ctrl_q         <= ctrl_d;
			wr_pend_q      <= wr_pend_d;
			wr_addr_q      <= wr_addr_d;
			hrdata         <= rdata_d;
			hreadyout      <= 1'b1;
			hresp          <= 1'b0;
			enc_state_q    <= enc_state_d;
			enc_fixed_q    <= enc_fixed_d;
			dec_state_q    <= dec_state_d;
			optical_tx_out <= tx_out_d;
			uart_rx_out    <= ~dec_busy;
			osc_run_out    <= osc_run_d;
		end
	end

	// ==========================================================
	// Checks
	a_osc_stop_cause: assert property (@(posedge hclk) disable iff (!hresetn)
		(pin_sync_q[PIN_SLEEP] | clk_ext_s) |=> !osc_run_out)
		else $error("Oscillator still runs while a stop cause is present.");

	a_ext_stops_osc: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_ext_s [*2] |-> !osc_run_out)
		else $error("External clock selected but oscillator not stopped.");

	a_fixed_pulse_len: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(enc_busy) && enc_fixed_q && $past(codec_rstn_s) |-> $past(enc_cnt) == 5'h05)
		else $error("Monoshot pulse did not last six crystal ticks.");

	a_bit_period_len: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(enc_busy) && !enc_fixed_q && $past(codec_rstn_s) |-> $past(enc_cnt) == 5'h0f)
		else $error("Encoder bit period not sixteen ticks.");

	a_rx_low_len: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(dec_busy) && $past(codec_rstn_s) |-> $past(dec_cnt) == 5'h0f ##1 uart_rx_out)
		else $error("Receive low period not sixteen ticks.");

	a_tx_fall_start: assert property (@(posedge hclk) disable iff (!hresetn)
		tx_fall && enc_state_q == ENC_IDLE && ctrl_q[CTRL_TX_EN_BIT] && codec_rstn_s
		|=> enc_busy ##1 optical_tx_out)
		else $error("Falling transmit edge did not start a pulse.");

	a_rx_pulse_start: assert property (@(posedge hclk) disable iff (!hresetn)
		dec_start |=> dec_busy ##1 !uart_rx_out)
		else $error("Received pulse did not drive serial output low.");

	a_codec_reset_idle: assert property (@(posedge hclk) disable iff (!hresetn)
		!codec_rstn_s |=> enc_state_q == ENC_IDLE && dec_state_q == DEC_IDLE && !enc_busy && !dec_busy)
		else $error("Codec reset did not idle the state machines.");

	a_clock_source: assert property (@(posedge hclk) disable iff (!hresetn)
		dec_busy && codec_rstn_s && !(clk_ext_s ? baud_rise : xtal_rise) |=> $stable(dec_cnt))
		else $error("Decoder counted without a tick of the selected clock.");

	a_mode_capture: assert property (@(posedge hclk) disable iff (!hresetn)
		enc_start && enc_state_q == ENC_IDLE |=> enc_fixed_q == $past(fixed_s))
		else $error("Pulse mode not taken from the select pin.");
endmodule : irc_codec

`default_nettype wire

// file: irc_codec_tb_top.sv
// Self-checking testbench of the infrared pulse codec.
`timescale 1ns/1ns
`default_nettype none

module irc_codec_tb_top;
	import irc_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        uart_tx_in = 1'b1;
	logic        uart_rx_out;
	logic        optical_rx_in = 1'b0;
	logic        optical_tx_out;
	logic        fixed_pulse_select = 1'b0;
	logic        osc_sleep_in = 1'b0;
	logic        clock_select_ext = 1'b0;
	logic        baud_x16_clock;
	logic        crystal_clock_in;
	logic        codec_reset_n = 1'b1;
	logic        osc_run_out;
	logic [31:0] rd;
	int          n;
	int          num_errors = 0;
	int          checks = 0;

	irc_codec DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .uart_tx_in(uart_tx_in), .uart_rx_out(uart_rx_out),
		.optical_rx_in(optical_rx_in), .optical_tx_out(optical_tx_out),
		.fixed_pulse_select(fixed_pulse_select), .osc_sleep_in(osc_sleep_in),
		.clock_select_ext(clock_select_ext), .baud_x16_clock(baud_x16_clock),
		.crystal_clock_in(crystal_clock_in), .codec_reset_n(codec_reset_n), .osc_run_out(osc_run_out));
	irc_clk_partner #(.XTAL_HALF(4), .BAUD_HALF(6)) partner (.hclk(hclk), .osc_run_out(osc_run_out),
		.crystal_clock_in(crystal_clock_in), .baud_x16_clock(baud_x16_clock));

	initial
	begin
		forever #50 hclk = ~hclk;
	end
	// ==========================================================
	// Shared tasks
	task automatic end_sim;
		if (num_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// A length in hclk cycles may stray by one tick of the selected clock either way.
	task automatic chk_len(input int got, input int ticks, input int half);
		checks++;
		if (got < 2 * half * (ticks - 1) || got > 2 * half * (ticks + 1))
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, 2 * half * ticks);
		end
	endtask : chk_len
	task automatic cyc(input int k);
		repeat (k) @(posedge hclk);
	endtask : cyc
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus
	// Waits a bounded time for the active level, then counts the cycles it lasts.
	task automatic meas(input logic tx, input logic act, output int len);
		int w;
		w = 0;
		len = 0;
		while ((tx ? optical_tx_out : uart_rx_out) !== act && w < 400)
		begin
			@(posedge hclk);
			w++;
		end
		while ((tx ? optical_tx_out : uart_rx_out) === act && len < 1000)
		begin
			@(posedge hclk);
			len++;
		end
	endtask : meas
	// ==========================================================
	// Scenarios
	task automatic t_regs;
		chk({27'h0, optical_tx_out, uart_rx_out, osc_run_out, hreadyout, hresp}, 32'h0000000e);
		bus(1'b0, 32'(CTRL_OFFSET), 32'h0, rd);
		chk(rd, 32'h00000003);
		bus(1'b0, 32'(STATUS_OFFSET), 32'h0, rd);
		chk(rd, 32'h00000004);
		bus(1'b0, 32'h00000040, 32'h0, rd);
		chk(rd, 32'h00000000);
	endtask : t_regs
	task automatic t_enc(input logic fixed);
		fixed_pulse_select <= fixed;
		cyc(4);
		uart_tx_in <= 1'b0;
		meas(1'b1, 1'b1, n);
		chk_len(n, fixed ? 6 : 3, 4);
		uart_tx_in <= 1'b1;
		meas(1'b1, 1'b1, n);
		chk(32'(n), 32'h0);
		fixed_pulse_select <= 1'b0;
		cyc(1);
	endtask : t_enc
	task automatic t_dec(input logic ext);
		clock_select_ext <= ext;
		cyc(6);
		chk(osc_run_out, {31'h0, ~ext});
		bus(1'b0, 32'(STATUS_OFFSET), 32'h0, rd);
		chk(rd, {27'h0, ext, 1'b1, ~ext, 2'b00});
		optical_rx_in <= 1'b1;
		cyc(4);
		optical_rx_in <= 1'b0;
		meas(1'b0, 1'b0, n);
		chk_len(n, 16, ext ? 6 : 4);
		clock_select_ext <= 1'b0;
		cyc(10);
	endtask : t_dec
	task automatic t_sleep;
		osc_sleep_in <= 1'b1;
		cyc(6);
		chk(osc_run_out, 1'b0);
		bus(1'b0, 32'(STATUS_OFFSET), 32'h0, rd);
		chk(rd, 32'h00000008);
		osc_sleep_in <= 1'b0;
		cyc(6);
		chk(osc_run_out, 1'b1);
	endtask : t_sleep
	task automatic t_creset;
		optical_rx_in <= 1'b1;
		cyc(4);
		optical_rx_in <= 1'b0;
		cyc(20);
		chk(uart_rx_out, 1'b0);
		bus(1'b0, 32'(STATUS_OFFSET), 32'h0, rd);
		chk(rd, 32'h0000000e);
		codec_reset_n <= 1'b0;
		cyc(8);
		chk({optical_tx_out, uart_rx_out}, 2'b01);
		codec_reset_n <= 1'b1;
		cyc(10);
	endtask : t_creset
	task automatic t_txoff;
		bus(1'b1, 32'(CTRL_OFFSET), 32'h00000002, rd);
		bus(1'b0, 32'(CTRL_OFFSET), 32'h0, rd);
		chk(rd, 32'h00000002);
		uart_tx_in <= 1'b0;
		meas(1'b1, 1'b1, n);
		chk(32'(n), 32'h0);
		uart_tx_in <= 1'b1;
		bus(1'b1, 32'(CTRL_OFFSET), 32'h00000003, rd);
		cyc(10);
	endtask : t_txoff
	// ==========================================================
	// Main sequence and watchdog
	initial
	begin
		cyc(8);
		hresetn <= 1'b1;
		cyc(6);
		t_regs();
		t_enc(1'b0);
		t_enc(1'b1);
		t_dec(1'b0);
		t_dec(1'b1);
		t_sleep();
		t_creset();
		t_txoff();
		end_sim();
	end
	initial
	begin
		#(30000 * 100);
		num_errors++;
		end_sim();
	end
endmodule : irc_codec_tb_top
`default_nettype wire

// file: irc_common.sv
// Shared constants and the tick-driven interval timer of the infrared pulse codec.
`timescale 1ns/1ns
`default_nettype none

package irc_pkg;
	// ==========================================================
	// Register map and reset values
	localparam logic [7:0]  CTRL_OFFSET       = 8'h00;
	localparam logic [7:0]  STATUS_OFFSET     = 8'h04;
	localparam int          CTRL_TX_EN_BIT    = 0;
	localparam int          CTRL_RX_EN_BIT    = 1;
	localparam logic [1:0]  CTRL_RESET        = 2'h3;
	localparam int          STAT_ENC_BUSY_BIT = 0;
	localparam int          STAT_DEC_BUSY_BIT = 1;
	localparam int          STAT_OSC_RUN_BIT  = 2;
	localparam int          STAT_FIXED_BIT    = 3;
	localparam int          STAT_CLK_EXT_BIT  = 4;
	// ==========================================================
	// Pin synchroniser layout
	localparam int          PIN_W             = 8;
	localparam int          PIN_TX            = 0;
	localparam int          PIN_RX            = 1;
	localparam int          PIN_FIXED         = 2;
	localparam int          PIN_SLEEP         = 3;
	localparam int          PIN_CLK_EXT       = 4;
	localparam int          PIN_BAUD          = 5;
	localparam int          PIN_XTAL          = 6;
	localparam int          PIN_CODEC_RSTN    = 7;
	localparam logic [7:0]  PIN_RESET         = 8'h81;
	// ==========================================================
	// Timing counts, in ticks of the selected clock; the fixed pulse count is in crystal ticks
	localparam int          CNT_W             = 5;
	localparam logic [4:0]  FIXED_PULSE_TICKS = 5'h06;
	localparam logic [4:0]  X16_PER_BIT       = 5'h10;
	localparam logic [4:0]  X16_PULSE_TICKS   = 5'h03;
	// ==========================================================
	// State machines
	typedef enum logic [1:0] {
		ENC_IDLE  = 2'b01,
		ENC_PULSE = 2'b10
	} irc_enc_state_t;
	typedef enum logic [1:0] {
		DEC_IDLE = 2'b01,
		DEC_LOW  = 2'b10
	} irc_dec_state_t;
endpackage : irc_pkg

// ==========================================================
// Interval timer
module irc_tick_timer #(
	parameter int W = 5
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         clear,
	input  wire logic         start,
	input  wire logic         tick,
	input  wire logic [W-1:0] limit,
	output var  logic         busy_q,
	output var  logic [W-1:0] count_q,
	output var  logic         done
);
	logic         busy_d;
	logic [W-1:0] count_d;

	if (W < 2)
	begin : g_bad_width
		$error("irc_tick_timer needs W of at least 2");
	end

	always_comb
	begin
		done    = busy_q && tick && (count_q == limit - {{(W-1){1'b0}}, 1'b1});
		busy_d  = busy_q;
		count_d = count_q;
		if (clear)
		begin
			busy_d  = 1'b0;
			count_d = '0;
		end
		else if (start)
		begin
			busy_d  = 1'b1;
			count_d = '0;
		end
		else if (done)
		begin
			busy_d  = 1'b0;
			count_d = '0;
		end
		else if (busy_q && tick)
		begin
			count_d = count_q + {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			busy_q  <= 1'b0;
			count_q <= '0;
		end
		else
		begin
			busy_q  <= busy_d;
			count_q <= count_d;
		end
	end
endmodule : irc_tick_timer

`default_nettype wire
